// ### hdl/tap_pkg.sv
/*
 * shared constants and types of the test access port:
 * instruction codes, chain widths, tap state encoding.
 * assumes a single system clock samples all test pins.
 */
package tap_pkg;

    // chain widths
    localparam int IR_W = 4;
    localparam int BSR_W = 8;
    localparam int ID_W = 32;
    localparam int SYNC_W = 4;

    // instruction codes
    localparam logic [IR_W-1:0] INS_EXTEST = 4'h0;
    localparam logic [IR_W-1:0] INS_INTEST = 4'h1;
    localparam logic [IR_W-1:0] INS_SAMPLE = 4'h2;
    localparam logic [IR_W-1:0] INS_TXN_CANCEL = 4'h8;
    localparam logic [IR_W-1:0] INS_DEBUG_PORT_ACCESS = 4'hA;
    localparam logic [IR_W-1:0] INS_ACCESS_PORT_ACCESS = 4'hB;
    localparam logic [IR_W-1:0] INS_IDCODE = 4'hE;
    localparam logic [IR_W-1:0] INS_BYPASS = 4'hF;

    // value the instruction chain captures; low bits 01 as the standard expects
    localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 4'h1;

    // identification value, arbitrary
    localparam logic [ID_W-1:0] ID_CODE_DEFAULT = 32'h0A5A_5001;

    // consecutive tms-high rising edges that always reach test-logic-reset
    localparam logic [2:0] TMS_RESET_LEN = 3'h5;

    // synchroniser bit positions
    localparam int SY_TRST = 0;
    localparam int SY_TCK = 1;
    localparam int SY_TMS = 2;
    localparam int SY_TDI = 3;

    typedef enum logic [15:0] {
        ST_RESET = 16'h0001,
        ST_IDLE = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SH_DR = 16'h0010,
        ST_EX1_DR = 16'h0020,
        ST_PAUSE_DR = 16'h0040,
        ST_EX2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SH_IR = 16'h0800,
        ST_EX1_IR = 16'h1000,
        ST_PAUSE_IR = 16'h2000,
        ST_EX2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } tap_state_t;

endpackage

// ### hdl/pin_sync.sv
/*
 * two-flop synchroniser for a group of pin inputs.
 * assumes the inputs are asynchronous to mclk; output is the second flop.
 */
`timescale 1ns/10ps
module pin_sync
    import tap_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // pins in, synchronised out
    input wire logic [W-1:0] pin,
    output logic [W-1:0] pin_s
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_state_t;

    sync_state_t r_ff;
    sync_state_t nxt_r;

    always_comb
    begin
        // first stage feeds only the second stage
        nxt_r.s1 = pin;
        nxt_r.s2 = r_ff.s1;
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            r_ff <= {RST_VAL, RST_VAL};
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    assign pin_s = r_ff.s2;

endmodule

// ### hdl/scan_chain.sv
/*
 * one serial shift chain with a parallel hold register.
 * assumes capture, shift and update are one-cycle strobes on mclk; init may stay high for many cycles.
 */
`timescale 1ns/10ps
module scan_chain
    import tap_pkg::*;
#(
    parameter int W = 4,
    parameter logic [W-1:0] INIT = '0
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // strobes
    input wire logic capture,
    input wire logic shift,
    input wire logic update,
    input wire logic init,
    // data
    input wire logic ser_in,
    input wire logic [W-1:0] par_in,
    output logic ser_out,
    output logic [W-1:0] par_out
);

    typedef struct packed {
        logic [W-1:0] sh;
        logic [W-1:0] hold;
    } chain_state_t;

    chain_state_t r_ff;
    chain_state_t nxt_r;

    always_comb
    begin
        nxt_r = r_ff;
        if (capture)
        begin
            nxt_r.sh = par_in;
        end
        else if (shift)
        begin
            // lsb leaves toward tdo, new bit enters at the msb
            for (int i = 0; i < W - 1; i++)
            begin
                nxt_r.sh[i] = r_ff.sh[i+1];
            end
            nxt_r.sh[W-1] = ser_in;
        end
        if (init)
        begin
            nxt_r.hold = INIT;
        end
        else if (update)
        begin
            nxt_r.hold = r_ff.sh;
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            r_ff <= {{W{1'b0}}, INIT};
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    assign ser_out = r_ff.sh[0];
    assign par_out = r_ff.hold;

endmodule

// ### hdl/jtag_tap_controller.sv
/*
 * test access port: tap state machine, instruction chain, bypass,
 * identification and boundary chains, and the tdo multiplexer between
 * the vendor test controller and the core debug controller.
 * assumes mclk is much faster than tck; all test pins are sampled on mclk.
 */
`timescale 1ns/10ps
module jtag_tap_controller
    import tap_pkg::*;
#(
    parameter logic [ID_W-1:0] ID_CODE = ID_CODE_DEFAULT
)
(
    // clock and power-on reset
    input wire logic mclk,
    input wire logic reset,
    // test port pins
    input wire logic trst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    // core debug controller
    output logic dbg_sel,
    output logic dbg_capture,
    output logic dbg_shift,
    output logic dbg_update,
    output logic dbg_tdi,
    input wire logic dbg_tdo,
    // boundary scan
    input wire logic [BSR_W-1:0] pad_sample,
    output logic [BSR_W-1:0] bsr_hold,
    output logic extest_on,
    output logic intest_on
);

    typedef struct packed {
        tap_state_t st;
        logic tck_prev;
        logic tdo;
        logic tdo_oe;
        logic dbg_sel;
        logic dbg_cap;
        logic dbg_shift;
        logic dbg_upd;
        logic dbg_tdi;
        logic extest;
        logic intest;
    } tap_regs_t;

    tap_regs_t r_ff;
    tap_regs_t nxt_r;

    logic [SYNC_W-1:0] pins_s;
    logic trst_n_s, tck_s, tms_s, tdi_s;
    logic tck_rise, tck_fall;
    logic [IR_W-1:0] ir_cur;
    logic ir_so, bsr_so, id_so, byp_so;
    logic sel_bsr, sel_id, sel_dbg, sel_ext, sel_int, sel_byp;
    logic cap_dr, sh_dr, upd_dr;
    logic ser_bit, drive;

    // trst and tck idle high, matching their pull-ups
    pin_sync #(.W(SYNC_W), .RST_VAL(4'h3)) u_sync (
        .mclk(mclk),
        .reset(reset),
        .pin({tdi, tms, tck, trst_n}),
        .pin_s(pins_s)
    );

    assign trst_n_s = pins_s[SY_TRST];
    assign tck_s = pins_s[SY_TCK];
    assign tms_s = pins_s[SY_TMS];
    assign tdi_s = pins_s[SY_TDI];

    // tms and tdi pass the same delay as tck, so the tester's falling-edge
    // changes are settled when the rising edge is seen here
    assign tck_rise = tck_s & ~r_ff.tck_prev;
    assign tck_fall = ~tck_s & r_ff.tck_prev;

    function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
        unique case (s)
            ST_RESET: tap_next = m ? ST_RESET : ST_IDLE;
            ST_IDLE: tap_next = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: tap_next = m ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: tap_next = m ? ST_EX2_DR : ST_PAUSE_DR;
            ST_EX2_DR: tap_next = m ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: tap_next = m ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: tap_next = m ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: tap_next = m ? ST_EX2_IR : ST_PAUSE_IR;
            ST_EX2_IR: tap_next = m ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_IDLE;
            default: tap_next = ST_RESET;
        endcase
    endfunction

    // instruction decode
    always_comb
    begin
        sel_ext = (ir_cur == INS_EXTEST);
        sel_int = (ir_cur == INS_INTEST);
        sel_bsr = (ir_cur == INS_SAMPLE);
        sel_id = (ir_cur == INS_IDCODE);
        sel_dbg = (ir_cur == INS_TXN_CANCEL) || (ir_cur == INS_DEBUG_PORT_ACCESS)
            || (ir_cur == INS_ACCESS_PORT_ACCESS);
        // every other code, 1111 included, falls back to bypass
        sel_byp = ~(sel_ext | sel_int | sel_bsr | sel_id | sel_dbg);
    end

    // data chain strobes only on a rising tck edge
    assign cap_dr = tck_rise && (r_ff.st == ST_CAP_DR);
    assign sh_dr = tck_rise && (r_ff.st == ST_SH_DR);
    assign upd_dr = tck_rise && (r_ff.st == ST_UPD_DR);

    // idcode loads on the very edge that enters test-logic-reset, so no late instruction change follows
    scan_chain #(.W(IR_W), .INIT(INS_IDCODE)) u_ir (
        .mclk(mclk),
        .reset(reset),
        .capture(tck_rise && (r_ff.st == ST_CAP_IR)),
        .shift(tck_rise && (r_ff.st == ST_SH_IR)),
        .update(tck_rise && (r_ff.st == ST_UPD_IR)),
        .init(nxt_r.st == ST_RESET),
        .ser_in(tdi_s),
        .par_in(IR_CAPTURE_VAL),
        .ser_out(ir_so),
        .par_out(ir_cur)
    );

    // extest and intest strobe nothing here: they only flag the boundary hold
    scan_chain #(.W(BSR_W), .INIT(8'h00)) u_bsr (
        .mclk(mclk),
        .reset(reset),
        .capture(cap_dr && sel_bsr),
        .shift(sh_dr && sel_bsr),
        .update(upd_dr && sel_bsr),
        .init(1'b0),
        .ser_in(tdi_s),
        .par_in(pad_sample),
        .ser_out(bsr_so),
        .par_out(bsr_hold)
    );

    scan_chain #(.W(ID_W), .INIT(32'h0000_0000)) u_id (
        .mclk(mclk),
        .reset(reset),
        .capture(cap_dr && sel_id),
        .shift(sh_dr && sel_id),
        .update(1'b0),
        .init(1'b0),
        .ser_in(tdi_s),
        .par_in(ID_CODE),
        .ser_out(id_so),
        .par_out()
    );

    scan_chain #(.W(1), .INIT(1'b0)) u_byp (
        .mclk(mclk),
        .reset(reset),
        .capture(cap_dr && sel_byp),
        .shift(sh_dr && sel_byp),
        .update(1'b0),
        .init(1'b0),
        .ser_in(tdi_s),
        .par_in(1'b0),
        .ser_out(byp_so),
        .par_out()
    );

    // tdo source: core debug output for its instructions, vendor chains otherwise
    always_comb
    begin
        ser_bit = 1'b0;
        drive = 1'b0;
        if (r_ff.st == ST_SH_IR)
        begin
            ser_bit = ir_so;
            drive = 1'b1;
        end
        else if (r_ff.st == ST_SH_DR)
        begin
            drive = ~(sel_ext | sel_int);
            if (sel_dbg)
            begin
                ser_bit = dbg_tdo;
            end
            else if (sel_bsr)
            begin
                ser_bit = bsr_so;
            end
            else if (sel_id)
            begin
                ser_bit = id_so;
            end
            else
            begin
                ser_bit = byp_so;
            end
        end
    end

    always_comb
    begin
        nxt_r = r_ff;
        nxt_r.tck_prev = tck_s;
        nxt_r.dbg_cap = cap_dr && sel_dbg;
        nxt_r.dbg_shift = sh_dr && sel_dbg;
        nxt_r.dbg_upd = upd_dr && sel_dbg;
        nxt_r.dbg_sel = sel_dbg;
        nxt_r.extest = sel_ext;
        nxt_r.intest = sel_int;
        if (sh_dr && sel_dbg)
        begin
            nxt_r.dbg_tdi = tdi_s;
        end
        // a stopped tck gives no edge, so nothing below moves except on trst
        if (!trst_n_s)
        begin
            nxt_r.st = ST_RESET;
        end
        else if (tck_rise)
        begin
            nxt_r.st = tap_next(r_ff.st, tms_s);
        end
        // tdo is released on a falling edge outside shift states, or at once on trst
        if (!trst_n_s)
        begin
            nxt_r.tdo_oe = 1'b0;
        end
        else if (tck_fall)
        begin
            nxt_r.tdo = drive ? ser_bit : 1'b0;
            nxt_r.tdo_oe = drive;
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            r_ff <= '{st: ST_RESET, tck_prev: 1'b1, default: 1'b0};
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    assign tdo = r_ff.tdo;
    assign tdo_oe = r_ff.tdo_oe;
    assign dbg_sel = r_ff.dbg_sel;
    assign dbg_capture = r_ff.dbg_cap;
    assign dbg_shift = r_ff.dbg_shift;
    assign dbg_update = r_ff.dbg_upd;
    assign dbg_tdi = r_ff.dbg_tdi;
    assign extest_on = r_ff.extest;
    assign intest_on = r_ff.intest;

    // helper: consecutive rising edges with tms high, saturating
    logic [2:0] tms_hi_cnt_ff;

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            tms_hi_cnt_ff <= 3'h0;
        end
        else if (tck_rise)
        begin
            tms_hi_cnt_ff <= !tms_s ? 3'h0 : (tms_hi_cnt_ff == TMS_RESET_LEN) ? tms_hi_cnt_ff : 3'(tms_hi_cnt_ff + 3'h1);
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    chk_state_still: assert property ((!tck_rise && trst_n_s) |=> $stable(r_ff.st) && $stable(ir_cur))
        else $error("tap state or instruction moved without a tck rising edge");
    chk_trst_hold: assert property (!trst_n_s |=> (r_ff.st == ST_RESET) && !r_ff.tdo_oe)
        else $error("trst low did not force test-logic-reset");
    chk_reset_idcode: assert property ((r_ff.st == ST_RESET) |=> (ir_cur == INS_IDCODE))
        else $error("instruction not idcode in test-logic-reset");
    chk_tms_five: assert property ((tms_hi_cnt_ff == TMS_RESET_LEN) |-> (r_ff.st == ST_RESET))
        else $error("five tms-high edges did not reach test-logic-reset");
    chk_tdo_fall: assert property ($changed(r_ff.tdo) |-> $past(tck_fall))
        else $error("tdo changed away from a tck falling edge");
    chk_tdo_release: assert property ((tck_fall && (r_ff.st != ST_SH_IR) && (r_ff.st != ST_SH_DR)) |=> !r_ff.tdo_oe)
        else $error("tdo driven outside a shift state");
    chk_ext_quiet: assert property ((sh_dr && (sel_ext || sel_int)) |=> $stable(bsr_so) ##8 !r_ff.tdo_oe)
        else $error("boundary chain moved or tdo driven in extest or intest");
    chk_dbg_mux: assert property ((tck_fall && (r_ff.st == ST_SH_DR) && sel_dbg) |=> r_ff.tdo_oe
        && (r_ff.tdo == $past(dbg_tdo)))
        else $error("tdo did not follow the core debug output");
    chk_byp_zero: assert property ((cap_dr && sel_byp) |=> (byp_so == 1'b0))
        else $error("bypass did not capture zero");
    chk_byp_delay: assert property ((sh_dr && sel_byp) |=> (byp_so == $past(tdi_s)))
        else $error("bypass did not pass tdi with one stage");
    chk_ir_update: assert property ((tck_rise && (r_ff.st == ST_UPD_IR) && trst_n_s) |=> (r_ff.st != ST_UPD_IR)
        && (ir_cur == $past(u_ir.r_ff.sh)))
        else $error("held instruction not loaded from the shift chain on update");

    cov_ir_shift: cover property ((r_ff.st == ST_SH_IR) ##1 (r_ff.st == ST_EX1_IR));
    cov_id_read: cover property (sh_dr && sel_id);
    cov_dbg_shift: cover property (r_ff.dbg_shift);
    cov_five_reset: cover property ((tms_hi_cnt_ff == TMS_RESET_LEN) && (r_ff.st == ST_RESET));

endmodule

// ### tb/jtag_probe.sv
/*
 * probe model: the external tester that clocks the test port pins.
 * assumes mclk at 100 MHz; tck period 160 ns with stall 0, edges placed just after mclk edges.
 */
`timescale 1ns/10ps
module jtag_probe
(
    // clock
    input wire logic mclk,
    // test port pins
    output logic trst_n,
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    logic tdo_w;
    logic seen_bit;
    int stall;
    event seen_ev;

    // tdo has a pull-up, so a released line reads high
    assign tdo_w = tdo_oe ? tdo : 1'b1;

    initial
    begin
        trst_n = 1'b1;
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        stall = 0;
    end

    // one tck period; tck idles low between bits, so it stands still outside frames
    task automatic bit_io(input logic m, input logic d, input logic chk);
        tms = m;
        tdi = d;
        repeat (8 + stall) @(posedge mclk);
        #1;
        tck = 1'b1;
        seen_bit = tdo_w;
        if (chk)
        begin
            -> seen_ev;
        end
        repeat (8 + stall) @(posedge mclk);
        #1;
        tck = 1'b0;
    endtask

    // tck stays low meanwhile; the reset must act without it
    task automatic pulse_trst(input int n);
        trst_n = 1'b0;
        repeat (n) @(posedge mclk);
        #1;
        trst_n = 1'b1;
    endtask
endmodule

// ### tb/tb_jtag_tap_controller.sv
/*
 * self-checking bench of the test access port: scans through the probe model,
 * a small core debug chain model, expected tdo bits queued and compared by a watcher.
 * assumes tap_pkg and the design files are compiled first.
 */
`timescale 1ns/10ps
module tb_jtag_tap_controller;
    import tap_pkg::*;
    logic mclk, reset, trst_n, tck, tms, tdi, tdo, tdo_oe;
    logic dbg_sel, dbg_capture, dbg_shift, dbg_update, dbg_tdi, dbg_tdo;
    logic extest_on, intest_on;
    logic [BSR_W-1:0] pad_sample, bsr_hold;
    logic [7:0] dsh, dhold, dcap, d;
    logic exp_q[$];
    int n_errors, n_tests;
    logic [IR_W-1:0] odd_codes[8] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hC, 4'hD};
    logic [IR_W-1:0] dbg_codes[3] = '{INS_TXN_CANCEL, INS_DEBUG_PORT_ACCESS, INS_ACCESS_PORT_ACCESS};

    jtag_tap_controller dut_u (.mclk(mclk), .reset(reset), .trst_n(trst_n), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .dbg_sel(dbg_sel), .dbg_capture(dbg_capture),
        .dbg_shift(dbg_shift), .dbg_update(dbg_update), .dbg_tdi(dbg_tdi), .dbg_tdo(dbg_tdo),
        .pad_sample(pad_sample), .bsr_hold(bsr_hold), .extest_on(extest_on), .intest_on(intest_on));
    jtag_probe probe_u (.mclk(mclk), .trst_n(trst_n), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe(tdo_oe));

    // core debug chain: 8-bit shift with hold, driven by the device strobes
    initial dsh = '0;
    always @(posedge mclk)
    begin
        if (dbg_capture) dsh <= dcap;
        else if (dbg_shift) dsh <= {dbg_tdi, dsh[7:1]};
        if (dbg_update) dhold <= dsh;
    end
    assign dbg_tdo = dsh[0];

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("errors %0d, comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic go(input logic m);
        probe_u.bit_io(m, 1'($urandom), 1'b0);
    endtask

    // from idle: shift code lsb first, expect the captured instruction value out
    task automatic ir_scan(input logic [IR_W-1:0] code);
        go(1); go(1); go(0); go(0);
        for (int i = 0; i < IR_W; i++)
        begin
            exp_q.push_back(IR_CAPTURE_VAL[i]);
            probe_u.bit_io(i == IR_W - 1, code[i], 1'b1);
        end
        go(1); go(0);
    endtask

    // from idle: n bits of din, expected tdo bits in ev, back to idle
    task automatic dr_scan(input int n, input logic [31:0] din, input logic [31:0] ev);
        go(1); go(0); go(0);
        for (int i = 0; i < n; i++)
        begin
            exp_q.push_back(ev[i]);
            probe_u.bit_io(i == n - 1, din[i], 1'b1);
        end
        go(1); go(0);
    endtask

    // watcher: each sampled tdo bit against the oldest expectation
    initial
    forever
    begin
        @(probe_u.seen_ev);
        if (exp_q.size() == 0)
            check(1'b0, 1'b1);
        else
            check(probe_u.seen_bit, exp_q.pop_front());
    end

    always @(tdo)
        if (reset === 1'b0) check(tck, 1'b0);

    initial
    begin
        repeat (60000) @(posedge mclk);
        n_errors++;
        summarize();
    end

    initial
    begin
        reset = 1'b1;
        pad_sample = '0;
        dcap = '0;
        n_errors = 0;
        n_tests = 0;
        void'($urandom(32'hf966f790));
        repeat (12) @(posedge mclk);
        #1;
        reset = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        check(tdo_oe, 1'b0);
        go(0);
        dr_scan(32, $urandom, ID_CODE_DEFAULT);
        probe_u.stall = 40;
        dr_scan(32, $urandom, ID_CODE_DEFAULT);
        probe_u.stall = 0;
        d = 8'($urandom);
        ir_scan(INS_BYPASS);
        dr_scan(8, d, {d, 1'b0});
        foreach (odd_codes[k])
        begin
            d = 8'($urandom);
            ir_scan(odd_codes[k]);
            check(dbg_sel, 1'b0);
            dr_scan(8, d, {d, 1'b0});
        end
        foreach (dbg_codes[k])
        begin
            d = 8'($urandom);
            dcap = 8'($urandom);
            ir_scan(dbg_codes[k]);
            check(dbg_sel, 1'b1);
            dr_scan(8, d, dcap);
            check(dhold, d);
        end
        d = 8'($urandom);
        pad_sample = 8'($urandom);
        ir_scan(INS_SAMPLE);
        dr_scan(8, d, pad_sample);
        check(bsr_hold, d);
        ir_scan(INS_EXTEST);
        check(extest_on, 1'b1);
        dr_scan(8, ~d, 32'hFFFF_FFFF);
        check(bsr_hold, d);
        ir_scan(INS_INTEST);
        check({extest_on, intest_on}, 2'h1);
        dr_scan(8, ~d, 32'hFFFF_FFFF);
        check(bsr_hold, d);
        ir_scan(INS_BYPASS);
        repeat (5) go(1);
        go(0);
        dr_scan(32, $urandom, ID_CODE_DEFAULT);
        ir_scan(INS_BYPASS);
        go(1); go(0); go(0);
        probe_u.pulse_trst(10);
        check(tdo_oe, 1'b0);
        repeat (4) @(posedge mclk);
        #1;
        go(0);
        dr_scan(32, $urandom, ID_CODE_DEFAULT);
        check(exp_q.size(), 0);
        summarize();
    end
endmodule
